// File: rtl/serial_port_consts.svh
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH
// Mode codes as {mode_select_hi, mode_select_lo}
`define MODE_SHIFT 2'h0
`define MODE_ASYNC8 2'h1
`define MODE_FIXED9 2'h2
`define MODE_ASYNC9 2'h3
// Shift-register mode: twelve core clocks per bit, clock high from count six
`define M0_CNT_LAST 4'hB
`define M0_HALF 4'h6
`define M0_BIT_LAST 4'h7
// Sixteen sample ticks per bit, start validated at the eighth
`define SAMPLE_LAST 4'hF
`define START_MID 4'h7
// Fixed-rate prescale reloads: 4 clocks per sample (/64), 2 clocks (/32)
`define M2_PRE_SLOW 2'h3
`define M2_PRE_FAST 2'h1
// Index of the stop bit in the transmit frame
`define TX_STOP_8 4'h9
`define TX_STOP_9 4'hA
// Index of the final receive sample
`define RX_FINAL_8 4'h8
`define RX_FINAL_9 4'h9
`endif

// File: rtl/serial_port_four_mode.sv
`include "serial_port_consts.svh"
`default_nettype none
// Summary of operation
// R1: Mode 0..3 chosen by the two mode-select bits, high bit first.
// R2: Mode 0 moves data on the data pin, drives shift clock, eight bits LSB first.
// R3: Any buffer write starts a transmission in every mode.
// R4: Mode 0 receive starts when receive allowed and receive-done clear.
// R5: Mode 0 bit rate is core clock divided by twelve.
// R6: Mode 1 frame: start 0, eight data bits LSB first, stop 1.
// R7: Modes 1 and 3 take bit rate from timer 1 or timer 2 overflow.
// R8: Mode 1 loads stop bit ninth; transmit-done sets when stop bit reaches line.
// R9: Async modes start receiving on a falling data line when allowed.
// R10: Mode 1 keeps frame only if done clear and multiproc check passes.
// R11: Modes 2 and 3 frame: start, eight data, ninth bit, stop.
// R12: Mode 2 rate is core clock over 64, or over 32 with baud double.
// R13: Modes 2, 3 send ninth field, start on next bit tick, done at stop.
// R14: Modes 2, 3 accept like mode 1, ninth bit to received-ninth field.
// R15: Mode 3 is mode 2 framing at timer-derived rate.
// R16: Timer 2 overflow flag never sets while it serves as rate source.
// R17: Timer 2 external flag still sets from its trigger input meanwhile.
// R18: Each direction picks timer 2 when its select is set, else timer 1.
// R19: Async receiver samples at sixteen times bit rate, mid-bit decisions.
module serial_port_four_mode (
   input wire logic I_MCLK,
   input wire logic I_RESET,
   input wire logic I_MODE_SELECT_HI,
   input wire logic I_MODE_SELECT_LO,
   input wire logic I_MULTIPROC_CHECK,
   input wire logic I_RECEIVE_ALLOW,
   input wire logic I_BAUD_DOUBLE,
   input wire logic I_TX_TIMER2_SELECT,
   input wire logic I_RX_TIMER2_SELECT,
   input wire logic I_TIMER1_OVERFLOW,
   input wire logic I_TIMER2_OVERFLOW,
   input wire logic I_TIMER2_TRIGGER_INPUT,
   input wire logic I_TIMER2_EXTERNAL_ENABLE,
   input wire logic I_TIMER2_OVERFLOW_CLEAR,
   input wire logic I_TIMER2_EXTERNAL_CLEAR,
   input wire logic I_BUFFER_WRITE,
   input wire logic [7:0] I_BUFFER_WDATA,
   input wire logic I_TRANSMIT_NINTH_BIT,
   input wire logic I_RECEIVE_DONE_CLEAR,
   input wire logic I_TRANSMIT_DONE_CLEAR,
   input wire logic I_RXD,
   output logic O_RXD,
   output logic O_RXD_OE_N,
   output logic O_TXD,
   output logic [7:0] O_SERIAL_BUFFER,
   output logic O_RECEIVED_NINTH_BIT,
   output logic O_RECEIVE_DONE_FLAG,
   output logic O_TRANSMIT_DONE_FLAG,
   output logic O_TIMER2_OVERFLOW_FLAG,
   output logic O_TIMER2_EXTERNAL_FLAG
);
   import serial_port_pkg::*;

   state_s s;
   state_s next_s;
   logic [1:0] mode;
   logic async_mode;
   logic nine;
   logic ptick;
   logic tx_tick;
   logic rx_tick;
   logic tx_bit_tick;
   logic [3:0] tx_last;
   logic [3:0] rx_last;
   logic rx_fell;
   logic trg_fell;
   logic rx_final;
   logic rx_accept;

   // Mode decode and rate selection
   assign mode = {I_MODE_SELECT_HI, I_MODE_SELECT_LO}; // see R1
   assign async_mode = (mode != `MODE_SHIFT);
   assign nine = I_MODE_SELECT_HI; // see R11
   assign ptick = (s.pdiv == 2'h0);
   // Fixed mode uses the prescaler, variable modes the chosen overflow
   assign tx_tick = (mode == `MODE_FIXED9) ? ptick :
                    (I_TX_TIMER2_SELECT ? I_TIMER2_OVERFLOW : I_TIMER1_OVERFLOW); // see R7, R18
   assign rx_tick = (mode == `MODE_FIXED9) ? ptick :
                    (I_RX_TIMER2_SELECT ? I_TIMER2_OVERFLOW : I_TIMER1_OVERFLOW); // see R15, R18
   assign tx_bit_tick = tx_tick && (s.tdiv == `SAMPLE_LAST);
   assign tx_last = nine ? `TX_STOP_9 : `TX_STOP_8;
   assign rx_last = nine ? `RX_FINAL_9 : `RX_FINAL_8;
   assign rx_fell = s.rxp && !s.rxv;
   assign trg_fell = s.trgp && !s.trgv;
   assign rx_final = (s.rst == R_DATA) && rx_tick && (s.rdiv == `SAMPLE_LAST) &&
                     (s.rbit == rx_last);
   // The stop bit is the line level at the final receive sample in both framings
   assign rx_accept = !s.rdone && (!I_MULTIPROC_CHECK || s.rxv); // see R10, R14

   // Next-state logic for the whole port
   always_comb begin
      logic tset;
      logic rset;
      tset = 1'b0;
      rset = 1'b0;
      next_s = s;
      // Pin synchronisers: a change counts once the last two stages agree
      next_s.rxs = {s.rxs[1], s.rxs[0], I_RXD};
      if (s.rxs[1] == s.rxs[2]) begin
         next_s.rxv = s.rxs[2];
      end
      next_s.rxp = s.rxv;
      next_s.trs = {s.trs[1], s.trs[0], I_TIMER2_TRIGGER_INPUT};
      if (s.trs[1] == s.trs[2]) begin
         next_s.trgv = s.trs[2];
      end
      next_s.trgp = s.trgv;
      // Fixed-rate prescaler, sixteen ticks make one bit
      next_s.pdiv = ptick ? (I_BAUD_DOUBLE ? `M2_PRE_FAST : `M2_PRE_SLOW) :
                    s.pdiv - 2'h1; // see R12
      if (tx_tick) begin
         next_s.tdiv = s.tdiv + 4'h1;
      end
      // Transmit and shift-register engine
      case (s.tst)
         T_IDLE: begin
         end
         T_WAIT: begin
            if (tx_bit_tick) begin // see R13
               next_s.tst = T_SHIFT;
               next_s.tbit = 4'h0;
               next_s.txd = s.tsh[0];
            end
         end
         T_SHIFT: begin
            if (tx_bit_tick) begin
               if (s.tbit == tx_last) begin
                  next_s.tst = T_IDLE;
               end else begin
                  next_s.tbit = s.tbit + 4'h1;
                  next_s.tsh = {1'b1, s.tsh[10:1]};
                  next_s.txd = s.tsh[1];
                  // Done flag rises as the stop bit goes onto the line
                  tset = ((s.tbit + 4'h1) == tx_last); // see R8, R13
               end
            end
         end
         T_M0TX, T_M0RX: begin
            next_s.m0cnt = (s.m0cnt == `M0_CNT_LAST) ? 4'h0 : s.m0cnt + 4'h1; // see R5
            next_s.txd = (next_s.m0cnt >= `M0_HALF); // see R2
            if (s.m0cnt == `M0_CNT_LAST) begin
               if (s.tst == T_M0RX) begin
                  next_s.tsh[7:0] = {s.rxv, s.tsh[7:1]}; // see R4
               end else begin
                  next_s.tsh[7:0] = {1'b1, s.tsh[7:1]};
                  next_s.rout = s.tsh[1]; // see R2
               end
               if (s.tbit == `M0_BIT_LAST) begin
                  next_s.tst = T_IDLE;
                  next_s.txd = 1'b1;
                  next_s.roe_n = 1'b1;
                  if (s.tst == T_M0RX) begin
                     next_s.buffer = {s.rxv, s.tsh[7:1]};
                     rset = 1'b1;
                  end else begin
                     tset = 1'b1;
                  end
               end else begin
                  next_s.tbit = s.tbit + 4'h1;
               end
            end
         end
         default: begin
            next_s.tst = T_IDLE;
         end
      endcase
      // A buffer write always restarts the transmitter
      if (I_BUFFER_WRITE) begin // see R3
         next_s.tbit = 4'h0;
         if (mode == `MODE_SHIFT) begin
            next_s.tst = T_M0TX;
            next_s.tsh = {3'h7, I_BUFFER_WDATA};
            next_s.rout = I_BUFFER_WDATA[0];
            next_s.roe_n = 1'b0;
            next_s.m0cnt = 4'h0;
            next_s.txd = 1'b0;
         end else begin
            // Ninth slot is the stop bit in mode 1, the ninth field otherwise
            next_s.tst = T_WAIT;
            next_s.tsh = {1'b1, (nine ? I_TRANSMIT_NINTH_BIT : 1'b1), I_BUFFER_WDATA,
                          1'b0}; // see R6, R8, R11, R13
            next_s.txd = 1'b1;
            next_s.roe_n = 1'b1;
         end
      end else if (!async_mode && s.tst == T_IDLE && I_RECEIVE_ALLOW && !s.rdone) begin
         next_s.tst = T_M0RX; // see R4
         next_s.tbit = 4'h0;
         next_s.m0cnt = 4'h0;
         next_s.txd = 1'b0;
         next_s.roe_n = 1'b1;
      end
      // Asynchronous receiver, sixteen samples per bit
      case (s.rst)
         R_IDLE: begin
            if (async_mode && I_RECEIVE_ALLOW && rx_fell) begin // see R9
               next_s.rst = R_START;
               next_s.rdiv = 4'h0;
            end
         end
         R_START: begin
            if (rx_tick) begin
               if (s.rdiv == `START_MID) begin // see R19
                  // A high line at mid start bit was a glitch
                  next_s.rst = s.rxv ? R_IDLE : R_DATA;
                  next_s.rdiv = 4'h0;
                  next_s.rbit = 4'h0;
               end else begin
                  next_s.rdiv = s.rdiv + 4'h1;
               end
            end
         end
         R_DATA: begin
            if (rx_tick) begin
               next_s.rdiv = s.rdiv + 4'h1;
               if (s.rdiv == `SAMPLE_LAST) begin // see R19
                  next_s.rbit = s.rbit + 4'h1;
                  if (s.rbit <= `RX_FINAL_8) begin
                     next_s.rsh = {s.rxv, s.rsh[8:1]};
                  end
               end
            end
            if (rx_final) begin
               next_s.rst = R_IDLE;
               if (rx_accept) begin // see R10, R14
                  rset = 1'b1;
                  next_s.buffer = nine ? s.rsh[7:0] : s.rsh[8:1];
                  next_s.rb8 = nine ? s.rsh[8] : s.rxv;
               end
            end
         end
         default: begin
            next_s.rst = R_IDLE;
         end
      endcase
      if (!async_mode) begin
         next_s.rst = R_IDLE;
      end
      // Hardware sets win over a clear in the same cycle
      next_s.tdone = tset || (s.tdone && !I_TRANSMIT_DONE_CLEAR);
      next_s.rdone = rset || (s.rdone && !I_RECEIVE_DONE_CLEAR);
      // Overflow flag held off while timer 2 serves as rate source
      next_s.t2ovf = (I_TIMER2_OVERFLOW && !I_TX_TIMER2_SELECT && !I_RX_TIMER2_SELECT) ||
                     (s.t2ovf && !I_TIMER2_OVERFLOW_CLEAR); // see R16
      next_s.t2ext = (trg_fell && I_TIMER2_EXTERNAL_ENABLE) ||
                     (s.t2ext && !I_TIMER2_EXTERNAL_CLEAR); // see R17
   end

   // State register; idle lines rest high
   always_ff @(posedge I_MCLK) begin
      if (I_RESET) begin
         s <= '0;
         s.txd <= 1'b1;
         s.rout <= 1'b1;
         s.roe_n <= 1'b1;
         s.rxs <= 3'h7;
         s.rxv <= 1'b1;
         s.rxp <= 1'b1;
         s.trs <= 3'h7;
         s.trgv <= 1'b1;
         s.trgp <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // Outputs come straight from the state register
   assign O_RXD = s.rout;
   assign O_RXD_OE_N = s.roe_n;
   assign O_TXD = s.txd;
   assign O_SERIAL_BUFFER = s.buffer;
   assign O_RECEIVED_NINTH_BIT = s.rb8;
   assign O_RECEIVE_DONE_FLAG = s.rdone;
   assign O_TRANSMIT_DONE_FLAG = s.tdone;
   assign O_TIMER2_OVERFLOW_FLAG = s.t2ovf;
   assign O_TIMER2_EXTERNAL_FLAG = s.t2ext;

   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (I_RESET);

   // One shift-clock bit: six low, six high
   sequence m0_bit_seq;
      !s.txd[*6] ##1 s.txd[*6];
   endsequence

   chk_write_starts_tx: assert property (I_BUFFER_WRITE |=> s.tst != T_IDLE) // see R3
      else $error("buffer write did not start transmit");
   // A buffer write restarts the engine, so it cancels any bit in flight
   chk_mode0_clock: assert property (disable iff (I_RESET || I_BUFFER_WRITE) // see R5
      (s.tst == T_M0TX || s.tst == T_M0RX) && s.m0cnt == 4'h0 &&
      s.tbit != `M0_BIT_LAST |-> m0_bit_seq)
      else $error("mode 0 shift clock not twelve cycles");
   chk_mode0_drive: assert property (s.tst == T_M0TX |-> !s.roe_n && s.rout == s.tsh[0]) // see R2
      else $error("mode 0 transmit not driving data pin");
   chk_start_bit: assert property ($rose(s.tst == T_SHIFT) |-> !s.txd) // see R6
      else $error("frame did not begin with start bit");
   chk_stop_done: assert property (s.tst == T_SHIFT && // see R8
      $changed(s.tbit) && s.tbit == tx_last |-> s.tdone && s.txd)
      else $error("stop bit on line without done flag");
   // Bit index moves once per 64 clocks: 1 + 7 + 56 cycles after a change
   chk_mode2_rate: assert property (s.tst == T_SHIFT && mode == `MODE_FIXED9 && // see R12
      $changed(s.tbit) && s.tbit < tx_last && !I_BAUD_DOUBLE
      ##1 (mode == `MODE_FIXED9 && !I_BAUD_DOUBLE && !I_BUFFER_WRITE)[*8]
      |-> ##56 $changed(s.tbit))
      else $error("mode 2 bit period not 64 clocks");
   chk_rx_start: assert property (async_mode && s.rst == R_IDLE && I_RECEIVE_ALLOW && // see R9
      rx_fell |=> s.rst == R_START)
      else $error("receiver missed falling start edge");
   chk_rx_discard: assert property (rx_final && !rx_accept |=> $stable(s.buffer) && // see R10
      $stable(s.rb8) && (s.rdone == $past(s.rdone) || $past(I_RECEIVE_DONE_CLEAR)))
      else $error("rejected frame changed buffer");
   chk_rx_accept: assert property (rx_final && rx_accept |=> s.rdone && // see R14
      s.rb8 == (nine ? $past(s.rsh[8]) : $past(s.rxv)))
      else $error("accepted frame not latched");
   chk_t2_no_ovf: assert property ((I_TX_TIMER2_SELECT || I_RX_TIMER2_SELECT) && // see R16
      !s.t2ovf |=> !s.t2ovf)
      else $error("timer 2 overflow flag set in rate mode");
   chk_t2_ext: assert property (trg_fell && I_TIMER2_EXTERNAL_ENABLE |=> s.t2ext) // see R17
      else $error("timer 2 external flag not set");

endmodule
`default_nettype wire

// File: rtl/serial_port_pkg.sv
`default_nettype none
package serial_port_pkg;
   typedef enum logic [2:0] {T_IDLE, T_WAIT, T_SHIFT, T_M0TX, T_M0RX} tx_state_e;
   typedef enum logic [1:0] {R_IDLE, R_START, R_DATA} rx_state_e;
   typedef struct packed {
      tx_state_e tst;
      logic [10:0] tsh;
      logic [3:0] tbit;
      logic [3:0] tdiv;
      logic [3:0] m0cnt;
      logic txd;
      logic rout;
      logic roe_n;
      rx_state_e rst;
      logic [8:0] rsh;
      logic [3:0] rbit;
      logic [3:0] rdiv;
      logic [7:0] buffer;
      logic rdone;
      logic tdone;
      logic rb8;
      logic [1:0] pdiv;
      logic [2:0] rxs;
      logic rxv;
      logic rxp;
      logic [2:0] trs;
      logic trgv;
      logic trgp;
      logic t2ovf;
      logic t2ext;
   } state_s;
endpackage
`default_nettype wire

// File: testbench/serial_peer.sv
`default_nettype none
// Far-side partner: async line sender and external mode 0 shift register
module serial_peer (
   input wire logic i_clk,
   input wire logic i_txd,
   input wire logic i_line,
   input wire logic i_oe_n,
   output var logic o_line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] src = 8'hFF;
   logic [7:0] got = 8'h00;
   logic rose = 1'b0;
   initial o_line = 1'b1;
   // Capture device bits on the rising shift clock while it drives the pin
   always @(posedge i_txd) begin
      if (!i_oe_n) begin
         got <= {i_line, got[7:1]};
      end else begin
         rose <= 1'b1;
      end
   end
   // Change data on the falling clock so it is steady through the high phase
   always @(negedge i_txd) begin
      if (i_oe_n && rose) begin
         src <= {1'b1, src[7:1]};
         o_line <= src[1];
      end
   end
   // Preload the byte the device will clock in, bit 0 first
   task automatic load(input logic [7:0] d);
      src <= d;
      rose <= 1'b0;
      o_line <= d[0];
   endtask
   // One async frame, LSB first; line returns to idle high afterwards
   task automatic send(input logic [10:0] bits, input int n, input int cpb);
      for (int i = 0; i < n; i++) begin
         o_line <= bits[i];
         repeat (cpb) @(posedge i_clk);
      end
      o_line <= 1'b1;
   endtask
endmodule
`default_nettype wire

// File: testbench/serial_port_four_mode_test.sv
`default_nettype none
module serial_port_four_mode_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [1:0] tmode [4] = '{2'h1, 2'h2, 2'h2, 2'h3};
   localparam int tcpb [4] = '{32, 64, 32, 48};
   localparam logic [7:0] tdat [4] = '{8'h35, 8'hCA, 8'h6B, 8'h94};
   localparam logic [10:0] rfrm [3] = '{{2'b01, 8'h3C, 1'b0}, {2'b10, 8'h96, 1'b0},
                                       {2'b11, 8'h11, 1'b0}};
   localparam logic [10:0] rexp [3] = '{{2'b10, 1'b0, 8'hC3}, {2'b01, 1'b0, 8'h96},
                                       {2'b01, 1'b0, 8'h96}};
   logic clk = 1'b0, rst = 1'b1, mpc = 1'b0, allow = 1'b0, bdbl = 1'b0;
   logic txsel = 1'b0, rxsel = 1'b0, t1 = 1'b0, t2 = 1'b0, trig = 1'b1, exen = 1'b0;
   logic oclr = 1'b0, eclr = 1'b0, wr = 1'b0, nb = 1'b0, rclr = 1'b0, tclr = 1'b0;
   logic [1:0] mode = 2'h0, c1 = 2'h0, c2 = 2'h0, dn;
   logic [7:0] wdata = 8'h00;
   logic [10:0] got, efrm;
   wire logic line, peer_line, d_rxd, oe_n, txd, rb8, rdone, tdone, t2f, t2x;
   wire logic [7:0] serial_buffer;
   int bad_count = 0, samples_checked = 0, n;
   // Device owns the data pin only while its enable is low
   assign line = oe_n ? peer_line : d_rxd;
   serial_port_four_mode i_serial_port_four_mode (.I_MCLK(clk), .I_RESET(rst),
      .I_MODE_SELECT_HI(mode[1]), .I_MODE_SELECT_LO(mode[0]), .I_MULTIPROC_CHECK(mpc),
      .I_RECEIVE_ALLOW(allow), .I_BAUD_DOUBLE(bdbl), .I_TX_TIMER2_SELECT(txsel),
      .I_RX_TIMER2_SELECT(rxsel), .I_TIMER1_OVERFLOW(t1), .I_TIMER2_OVERFLOW(t2),
      .I_TIMER2_TRIGGER_INPUT(trig), .I_TIMER2_EXTERNAL_ENABLE(exen),
      .I_TIMER2_OVERFLOW_CLEAR(oclr), .I_TIMER2_EXTERNAL_CLEAR(eclr), .I_BUFFER_WRITE(wr),
      .I_BUFFER_WDATA(wdata), .I_TRANSMIT_NINTH_BIT(nb), .I_RECEIVE_DONE_CLEAR(rclr),
      .I_TRANSMIT_DONE_CLEAR(tclr), .I_RXD(line), .O_RXD(d_rxd), .O_RXD_OE_N(oe_n),
      .O_TXD(txd), .O_SERIAL_BUFFER(serial_buffer), .O_RECEIVED_NINTH_BIT(rb8),
      .O_RECEIVE_DONE_FLAG(rdone), .O_TRANSMIT_DONE_FLAG(tdone),
      .O_TIMER2_OVERFLOW_FLAG(t2f), .O_TIMER2_EXTERNAL_FLAG(t2x));
   serial_peer i_serial_peer (.i_clk(clk), .i_txd(txd), .i_line(line), .i_oe_n(oe_n),
      .o_line(peer_line));
   always #25 clk = ~clk;
   // Overflow stand-ins: timer 1 every 2 clocks, timer 2 every 3 clocks
   always @(posedge clk) begin
      c1 <= c1 ^ 2'h1;
      c2 <= (c2 == 2'h2) ? 2'h0 : c2 + 2'h1;
      t1 <= c1[0];
      t2 <= (c2 == 2'h2);
   end
   task automatic check(input logic [10:0] g, input logic [10:0] e);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic write_buf(input logic [7:0] d, input logic ninth);
      @(posedge clk);
      wr <= 1'b1;
      wdata <= d;
      nb <= ninth;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Clear every sticky flag for one cycle; overflow sources keep running meanwhile
   task automatic clear_all();
      @(posedge clk);
      {rclr, tclr, oclr, eclr} <= 4'hF;
      @(posedge clk);
      {rclr, tclr, oclr, eclr} <= 4'h0;
   endtask
   // Sample a frame at bit centres; dn holds the done flag at the last two bits
   task automatic grab_tx(input int nb_bits, input int cpb, output logic [10:0] bits,
                          output logic [1:0] d);
      int k;
      k = 0;
      bits = 11'h000;
      d = 2'h0;
      while (txd !== 1'b0 && k < 4000) begin
         @(posedge clk);
         k++;
      end
      repeat (cpb / 2) @(posedge clk);
      for (int i = 0; i < nb_bits; i++) begin
         bits[i] = txd;
         if (i >= nb_bits - 2) d[i - nb_bits + 2] = tdone;
         repeat (cpb) @(posedge clk);
      end
   endtask
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Longest test set is a few thousand cycles; this bound catches a hang
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      final_report();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      // Shift-register transmit: enable low for eight twelve-clock bits
      write_buf(8'hA5, 1'b0);
      n = 0;
      repeat (200) begin
         @(posedge clk);
         if (oe_n === 1'b0) n++;
      end
      check(11'(n), 11'h060);
      check(11'(i_serial_peer.got), 11'h0A5);
      check(11'(tdone), 11'h001);
      $display("Test mode 0 transmit finished");
      i_serial_peer.load(8'h5C);
      @(posedge clk);
      allow <= 1'b1;
      repeat (150) @(posedge clk);
      check({2'b00, rdone, serial_buffer}, 11'h15C);
      allow <= 1'b0;
      $display("Test mode 0 receive finished");
      // Async transmit in every framing and rate source
      for (int k = 0; k < 4; k++) begin
         clear_all();
         mode <= tmode[k];
         bdbl <= (k == 2);
         txsel <= (k == 3);
         fork
            write_buf(tdat[k], 1'(k % 2));
            grab_tx((k == 0) ? 10 : 11, tcpb[k], got, dn);
         join
         efrm = (k == 0) ? {2'b01, tdat[k], 1'b0} : {1'b1, 1'(k % 2), tdat[k], 1'b0};
         check(got, efrm);
         check(11'(dn), 11'h002);
      end
      $display("Test async transmit finished");
      mode <= 2'h1;
      rxsel <= 1'b1;
      allow <= 1'b1;
      clear_all();
      i_serial_peer.send({2'b01, 8'hC3, 1'b0}, 10, 48);
      repeat (10) @(posedge clk);
      check({rb8, rdone, 1'b0, serial_buffer}, {2'b11, 1'b0, 8'hC3});
      // Ninth-bit frames: bad stop discarded, good kept, then refused while done set
      mode <= 2'h3;
      mpc <= 1'b1;
      clear_all();
      for (int k = 0; k < 3; k++) begin
         i_serial_peer.send(rfrm[k], 11, 48);
         repeat (10) @(posedge clk);
         check({rb8, rdone, 1'b0, serial_buffer}, rexp[k]);
      end
      $display("Test async receive finished");
      allow <= 1'b0;
      rxsel <= 1'b1;
      exen <= 1'b1;
      clear_all();
      repeat (12) @(posedge clk);
      check(11'(t2f), 11'h000);
      trig <= 1'b0;
      repeat (8) @(posedge clk);
      check(11'(t2x), 11'h001);
      {rxsel, txsel} <= 2'h0;
      repeat (8) @(posedge clk);
      check(11'(t2f), 11'h001);
      $display("Test timer 2 flags finished");
      final_report();
   end
endmodule
`default_nettype wire
